// File: verilog/siu_top.v
// Serial module and UART interrupt control with register bus slave
// Overview of operation
// - Serial flag sets on any of four serial module events.
// - Serial vector needs global enable, serial enable and flag.
// - No vector call while the return stack is full.
// - Serial service clears its flag and the global enable.
// - UART request raised by any of six UART conditions.
// - UART vector needs global enable, UART enable and pending flag.
// - UART service clears UART flag and global enable.
// - UART service leaves UART status flags untouched.
// - Any request flag rising produces a wake-up.
// - Wake-up ignores every enable bit.
// - A set flag stays set until serviced or cleared.
// - Group entry clears only the grouped flag, not source flags.
// - Entry pushes only the program counter.
// - Return with re-enable sets the global enable.
// - Plain return leaves the global enable cleared.
// - Grouped flag sets when any of its source flags sets.
`timescale 1ns/10ps
`include "siu_map.vh"
module siu_top
(
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  input wire [3:0] I_SERIAL_MODULE_EV,
  input wire [5:0] I_UART_EV,
  input wire [5:0] I_UART_STAT_CLR,
  input wire [1:0] I_GROUP_SRC_EV,
  input wire I_STACK_FULL,
  input wire I_VEC_ACK,
  input wire I_RETURN_WITH_REENABLE,
  input wire I_PLAIN_RETURN,
  input wire [`SIU_PC_W-1:0] I_PC,
  output reg O_VEC_REQ,
  output reg [1:0] O_VEC_ID,
  output reg O_STACK_PUSH,
  output reg [`SIU_PC_W-1:0] O_PUSH_PC,
  output reg O_WAKE,
  output reg O_GLOBAL_IRQ_ENABLE
);

  // One-hot states of the vectoring sequencer
  localparam ST_IDLE = 2'h1;
  localparam ST_REQ = 2'h2;

  wire rst_n;
  reg [1:0] state;
  reg [3:0] ctrl;
  reg [5:0] uart_status_flags;
  reg next_gie;
  reg [5:0] next_status;

  // Write channel holding state
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane;

  // Flag outputs
  wire serial_module_request_flag;
  wire uart_request_flag;
  wire grouped_request_flag;
  wire [1:0] src_flag;
  wire sm_rise;
  wire uart_rise;
  wire grp_rise;
  wire [1:0] src_rise;

  // Reset release through two flops
  siu_rst_sync u_rst
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESETN),
    .o_rst_n(rst_n)
  );

  // Bus handshakes
  wire aw_hs = I_AWVALID & O_AWREADY;
  wire w_hs = I_WVALID & O_WREADY;
  wire b_hs = O_BVALID & I_BREADY;
  wire ar_hs = I_ARVALID & O_ARREADY;
  wire r_hs = O_RVALID & I_RREADY;
  wire wr_fire = aw_got & w_got & ~O_BVALID;

  // Write decode; only the low byte carries bits
  wire wr_ctrl = wr_fire & (aw_addr == `SIU_CTRL_OFS);
  wire wr_flags = wr_fire & (aw_addr == `SIU_FLAGS_OFS);
  wire wr_ro = wr_fire & ((aw_addr == `SIU_STATUS_OFS) |
                          (aw_addr == `SIU_VECTOR_OFS));
  wire wr_ok = wr_ctrl | wr_flags | wr_ro;
  wire flags_we = wr_flags & w_lane;

  // Enables
  wire gie = ctrl[`SIU_CTRL_GIE];
  wire sm_en = ctrl[`SIU_CTRL_SM_EN];
  wire uart_en = ctrl[`SIU_CTRL_UART_EN];
  wire grp_en = ctrl[`SIU_CTRL_GRP_EN];

  // Per-vector readiness, gated by the global enable
  wire sm_go = gie & sm_en & serial_module_request_flag;
  wire uart_go = gie & uart_en & uart_request_flag;
  wire grp_go = gie & grp_en & grouped_request_flag;
  wire any_go = (sm_go | uart_go | grp_go) & ~I_STACK_FULL;

  // Fixed priority: serial, then UART, then group
  wire [1:0] pick = sm_go ? `SIU_VEC_SM :
                    (uart_go ? `SIU_VEC_UART : `SIU_VEC_GRP);

  // Is the latched vector still callable
  wire sel_go = (O_VEC_ID == `SIU_VEC_SM) ? sm_go :
                ((O_VEC_ID == `SIU_VEC_UART) ? uart_go : grp_go);
  wire still_ok = sel_go & ~I_STACK_FULL;

  // Entry happens when the core takes the offered vector
  wire entry = (state == ST_REQ) & I_VEC_ACK & still_ok;
  wire clr_sm = entry & (O_VEC_ID == `SIU_VEC_SM);
  wire clr_uart = entry & (O_VEC_ID == `SIU_VEC_UART);
  wire clr_grp = entry & (O_VEC_ID == `SIU_VEC_GRP);

  // Serial module request flag
  siu_flag u_sm_flag
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_set(|I_SERIAL_MODULE_EV),
    .i_clr(clr_sm),
    .i_we(flags_we),
    .i_wdata(w_byte[`SIU_FLG_SM]),
    .o_flag(serial_module_request_flag),
    .o_rise(sm_rise)
  );

  // UART request flag
  siu_flag u_uart_flag
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_set(|I_UART_EV),
    .i_clr(clr_uart),
    .i_we(flags_we),
    .i_wdata(w_byte[`SIU_FLG_UART]),
    .o_flag(uart_request_flag),
    .o_rise(uart_rise)
  );

  // Grouped flag follows any source flag going high
  siu_flag u_grp_flag
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_set(|src_rise),
    .i_clr(clr_grp),
    .i_we(flags_we),
    .i_wdata(w_byte[`SIU_FLG_GRP]),
    .o_flag(grouped_request_flag),
    .o_rise(grp_rise)
  );

  // Source flags are never cleared by entry, only by software
  siu_flag u_src0_flag
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_set(I_GROUP_SRC_EV[0]),
    .i_clr(1'b0),
    .i_we(flags_we),
    .i_wdata(w_byte[`SIU_FLG_SRC0]),
    .o_flag(src_flag[0]),
    .o_rise(src_rise[0])
  );

  siu_flag u_src1_flag
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_set(I_GROUP_SRC_EV[1]),
    .i_clr(1'b0),
    .i_we(flags_we),
    .i_wdata(w_byte[`SIU_FLG_SRC1]),
    .o_flag(src_flag[1]),
    .o_rise(src_rise[1])
  );

  // Global enable: entry clear wins, then re-enable, then software
  always @*
  begin
    next_gie = gie;
    if (wr_ctrl & w_lane)
      next_gie = w_byte[`SIU_CTRL_GIE];
    if (I_RETURN_WITH_REENABLE)
      next_gie = 1'b1;
    else if (I_PLAIN_RETURN)
      next_gie = next_gie;
    if (entry)
      next_gie = 1'b0;
  end

  // Control register
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= `SIU_CTRL_RST;
    else
    begin
      ctrl[`SIU_CTRL_GIE] <= next_gie;
      if (wr_ctrl & w_lane)
        ctrl[3:1] <= w_byte[3:1];
    end
  end

  // UART status: set wins, cleared only by the UART itself
  always @*
  begin
    next_status = (uart_status_flags & ~I_UART_STAT_CLR) | I_UART_EV;
  end

  // Interrupt entry has no path into these bits
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      uart_status_flags <= 6'h00;
    else
      uart_status_flags <= next_status;
  end

  // Vectoring sequencer
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      O_VEC_REQ <= 1'b0;
      O_VEC_ID <= `SIU_VEC_SM;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (any_go)
          begin
            state <= ST_REQ;
            O_VEC_REQ <= 1'b1;
            O_VEC_ID <= pick;
          end
        end
        ST_REQ:
        begin
          // Withdraw if the core took it or it lost its right
          if (entry | ~still_ok)
          begin
            state <= ST_IDLE;
            O_VEC_REQ <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          O_VEC_REQ <= 1'b0;
        end
      endcase
    end
  end

  // Only the program counter goes onto the stack
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_STACK_PUSH <= 1'b0;
      O_PUSH_PC <= {`SIU_PC_W{1'b0}};
    end
    else
    begin
      O_STACK_PUSH <= entry;
      if (entry)
        O_PUSH_PC <= I_PC;
    end
  end

  // Wake from any rising request flag, enables not consulted
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_WAKE <= 1'b0;
    else
      O_WAKE <= sm_rise | uart_rise | grp_rise | (|src_rise);
  end

  // Mirror of the global enable for the core
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_GLOBAL_IRQ_ENABLE <= 1'b0;
    else
      O_GLOBAL_IRQ_ENABLE <= next_gie;
  end

  // Write address and data are taken in either order
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `SIU_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got <= 1'b1;
        aw_addr <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (w_hs)
      begin
        w_got <= 1'b1;
        w_byte <= I_WDATA[7:0];
        w_lane <= I_WSTRB[0];
        O_WREADY <= 1'b0;
      end
      // Response follows once both halves are held
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_ok ? `SIU_RESP_OKAY : `SIU_RESP_SLVERR;
      end
      // Ready again only after the response is gone
      if (b_hs)
      begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // Read data, captured at the address handshake
  always @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `SIU_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RRESP <= `SIU_RESP_OKAY;
      if (I_ARADDR == `SIU_CTRL_OFS)
        O_RDATA <= {28'h0000000, ctrl};
      else if (I_ARADDR == `SIU_FLAGS_OFS)
        O_RDATA <= {27'h0000000, src_flag, grouped_request_flag,
                    uart_request_flag, serial_module_request_flag};
      else if (I_ARADDR == `SIU_STATUS_OFS)
        O_RDATA <= {26'h0000000, uart_status_flags};
      else if (I_ARADDR == `SIU_VECTOR_OFS)
        O_RDATA <= {29'h00000000, O_VEC_REQ, O_VEC_ID};
      else
      begin
        O_RDATA <= 32'h00000000;
        O_RRESP <= `SIU_RESP_SLVERR;
      end
    end
    else if (r_hs)
    begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

endmodule // siu_top

// File: verilog/siu_map.vh
// Register map, field positions and codes of the interrupt logic
`ifndef SIU_MAP_VH
`define SIU_MAP_VH
// Byte addresses on the register bus
`define SIU_CTRL_OFS 8'h00
`define SIU_FLAGS_OFS 8'h04
`define SIU_STATUS_OFS 8'h08
`define SIU_VECTOR_OFS 8'h0C
// Control register fields
`define SIU_CTRL_GIE 0
`define SIU_CTRL_SM_EN 1
`define SIU_CTRL_UART_EN 2
`define SIU_CTRL_GRP_EN 3
`define SIU_CTRL_RST 4'h0
// Flag register fields
`define SIU_FLG_SM 0
`define SIU_FLG_UART 1
`define SIU_FLG_GRP 2
`define SIU_FLG_SRC0 3
`define SIU_FLG_SRC1 4
// Vector codes, lowest code wins
`define SIU_VEC_SM 2'h0
`define SIU_VEC_UART 2'h1
`define SIU_VEC_GRP 2'h2
// Bus responses
`define SIU_RESP_OKAY 2'h0
`define SIU_RESP_SLVERR 2'h2
// Widths
`define SIU_PC_W 16
`endif

// File: verilog/siu_rst_sync.v
// Reset release synchroniser of the interrupt logic
`timescale 1ns/10ps
module siu_rst_sync
(
  input wire i_clk,
  input wire i_rst_n,
  output reg o_rst_n
);

  reg meta_n;

  // Assert at once, release after two edges
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_n <= 1'b0;
      o_rst_n <= 1'b0;
    end
    else
    begin
      meta_n <= 1'b1;
      o_rst_n <= meta_n;
    end
  end

endmodule // siu_rst_sync

// File: verilog/siu_flag.v
// One sticky request flag with write access and rise detection
`timescale 1ns/10ps
module siu_flag
(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_set,
  input wire i_clr,
  input wire i_we,
  input wire i_wdata,
  output reg o_flag,
  output wire o_rise
);

  reg prev;
  reg next_flag;

  // Hardware set beats both service clear and software write
  always @*
  begin
    next_flag = o_flag;
    if (i_we)
      next_flag = i_wdata;
    if (i_clr)
      next_flag = 1'b0;
    if (i_set)
      next_flag = 1'b1;
  end

  // Flag holds until cleared; enables never touch it
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_flag <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      o_flag <= next_flag;
      prev <= o_flag;
    end
  end

  // One cycle per low-to-high change
  assign o_rise = o_flag & ~prev;

endmodule // siu_flag

// File: dv/siu_core_model.sv
// Core sequencer model that answers vector offers
`timescale 1ns/10ps
module siu_core_model
(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_vec_req,
  input wire [2:0] i_lag,
  output reg o_vec_ack
);
  reg [2:0] wait_cnt;
  // Ack i_lag+1 cycles after the offer, one ack per offer
  // Acks any standing offer, inside a service routine or not
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_cnt <= 3'h0;
      o_vec_ack <= 1'b0;
    end
    else if (!i_vec_req || o_vec_ack)
    begin
      wait_cnt <= 3'h0;
      o_vec_ack <= 1'b0;
    end
    else if (wait_cnt == i_lag)
      o_vec_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 3'h1;
  end
endmodule // siu_core_model

// File: dv/siu_checker.sv
// Port checker of the interrupt logic
`timescale 1ns/10ps
`include "siu_map.vh"
module siu_checker
(
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire [3:0] I_SERIAL_MODULE_EV,
  input wire [5:0] I_UART_EV,
  input wire [1:0] I_GROUP_SRC_EV,
  input wire I_STACK_FULL,
  input wire I_VEC_ACK,
  input wire I_RETURN_WITH_REENABLE,
  input wire I_PLAIN_RETURN,
  input wire I_WVALID,
  input wire [`SIU_PC_W-1:0] I_PC,
  input wire O_VEC_REQ,
  input wire [1:0] O_VEC_ID,
  input wire O_STACK_PUSH,
  input wire [`SIU_PC_W-1:0] O_PUSH_PC,
  input wire O_WAKE,
  input wire O_GLOBAL_IRQ_ENABLE,
  input wire O_WREADY,
  input wire O_BVALID
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);
  wire ev_any = |{I_SERIAL_MODULE_EV, I_UART_EV, I_GROUP_SRC_EV};
  // Core takes the offered vector
  sequence s_entry;
    O_VEC_REQ && I_VEC_ACK && !I_STACK_FULL;
  endsequence
  // No bus write can land at the next edge
  wire no_wr = O_WREADY && !I_WVALID;
  AST_ENTRY: assert property (
    s_entry |=> O_STACK_PUSH && !O_VEC_REQ && !O_GLOBAL_IRQ_ENABLE)
    else $error("entry did not push or clear enable");
  AST_PUSH_PC: assert property (
    s_entry |=> O_PUSH_PC == $past(I_PC))
    else $error("pushed pc differs");
  AST_PUSH_ONE: assert property (
    O_STACK_PUSH |-> $past(O_VEC_REQ) && $past(I_VEC_ACK) ##1 !O_STACK_PUSH)
    else $error("push without entry or too long");
  AST_OFFER: assert property (
    $rose(O_VEC_REQ) |-> !$past(I_STACK_FULL) && $past(O_GLOBAL_IRQ_ENABLE))
    else $error("offer without enable or with full stack");
  AST_FULL_DROP: assert property (
    I_STACK_FULL |=> !O_VEC_REQ)
    else $error("offer stands with full stack");
  AST_RETURN_WITH_REENABLE: assert property (
    I_RETURN_WITH_REENABLE && !I_VEC_ACK && no_wr |=> O_GLOBAL_IRQ_ENABLE)
    else $error("reenable return left enable low");
  AST_RET: assert property (
    I_PLAIN_RETURN && !I_RETURN_WITH_REENABLE && !O_GLOBAL_IRQ_ENABLE
    && no_wr |=> !O_GLOBAL_IRQ_ENABLE)
    else $error("plain return changed enable");
  AST_WAKE: assert property (
    O_WAKE |-> $past(ev_any, 2) || $past(ev_any, 3) || $past(O_BVALID)
    || $past(O_BVALID, 2))
    else $error("wake without a rising cause");
  AST_ID_HOLD: assert property (
    O_VEC_REQ && $past(O_VEC_REQ) |-> $stable(O_VEC_ID))
    else $error("vector id moved during offer");
endmodule // siu_checker
bind siu_top siu_checker i_chk
(
  .I_CORE_CLK(I_CORE_CLK),
  .I_RESETN(I_RESETN),
  .I_SERIAL_MODULE_EV(I_SERIAL_MODULE_EV),
  .I_UART_EV(I_UART_EV),
  .I_GROUP_SRC_EV(I_GROUP_SRC_EV),
  .I_STACK_FULL(I_STACK_FULL),
  .I_VEC_ACK(I_VEC_ACK),
  .I_RETURN_WITH_REENABLE(I_RETURN_WITH_REENABLE),
  .I_PLAIN_RETURN(I_PLAIN_RETURN),
  .I_WVALID(I_WVALID),
  .I_PC(I_PC),
  .O_VEC_REQ(O_VEC_REQ),
  .O_VEC_ID(O_VEC_ID),
  .O_STACK_PUSH(O_STACK_PUSH),
  .O_PUSH_PC(O_PUSH_PC),
  .O_WAKE(O_WAKE),
  .O_GLOBAL_IRQ_ENABLE(O_GLOBAL_IRQ_ENABLE),
  .O_WREADY(O_WREADY),
  .O_BVALID(O_BVALID)
);

// File: dv/siu_top_tb.sv
// Self-checking bench of the interrupt logic
`timescale 1ns/10ps
`include "siu_map.vh"
module siu_top_tb;
  reg I_CORE_CLK, I_RESETN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID;
  reg I_RREADY, I_STACK_FULL, I_RETURN_WITH_REENABLE, I_PLAIN_RETURN;
  reg [7:0] I_AWADDR, I_ARADDR;
  reg [31:0] I_WDATA, seed, rd;
  reg [3:0] I_SERIAL_MODULE_EV;
  reg [5:0] I_UART_EV, I_UART_STAT_CLR;
  reg [1:0] I_GROUP_SRC_EV, rsp;
  reg [`SIU_PC_W-1:0] I_PC;
  reg [2:0] lag;
  reg [3:0] I_WSTRB;
  wire I_VEC_ACK, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  wire O_VEC_REQ, O_STACK_PUSH, O_WAKE, O_GLOBAL_IRQ_ENABLE;
  wire [1:0] O_BRESP, O_RRESP, O_VEC_ID;
  wire [31:0] O_RDATA;
  wire [`SIU_PC_W-1:0] O_PUSH_PC;
  integer fails, n_compared, i;
  siu_top i_dut
  (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RESETN(I_RESETN),
    .I_AWADDR(I_AWADDR),
    .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB),
    .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY),
    .I_ARADDR(I_ARADDR),
    .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP),
    .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY),
    .I_SERIAL_MODULE_EV(I_SERIAL_MODULE_EV),
    .I_UART_EV(I_UART_EV),
    .I_UART_STAT_CLR(I_UART_STAT_CLR),
    .I_GROUP_SRC_EV(I_GROUP_SRC_EV),
    .I_STACK_FULL(I_STACK_FULL),
    .I_VEC_ACK(I_VEC_ACK),
    .I_RETURN_WITH_REENABLE(I_RETURN_WITH_REENABLE),
    .I_PLAIN_RETURN(I_PLAIN_RETURN),
    .I_PC(I_PC),
    .O_VEC_REQ(O_VEC_REQ),
    .O_VEC_ID(O_VEC_ID),
    .O_STACK_PUSH(O_STACK_PUSH),
    .O_PUSH_PC(O_PUSH_PC),
    .O_WAKE(O_WAKE),
    .O_GLOBAL_IRQ_ENABLE(O_GLOBAL_IRQ_ENABLE)
  );
  siu_core_model i_core
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESETN),
    .i_vec_req(O_VEC_REQ),
    .i_lag(lag),
    .o_vec_ack(I_VEC_ACK)
  );
  // 10 MHz clock
  always #50 I_CORE_CLK = ~I_CORE_CLK;
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Five flag bits; a rising source flag also raises the group flag
  function [31:0] exp_flags(input [31:0] d);
    exp_flags = (d & 32'h0000001F) | {29'h0, |d[4:3], 2'h0};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        fails = fails + 1;
      end
    end
  endtask
  task complete_run;
    begin
      if (fails == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Readies are read at the falling edge, so they match the next rise
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tb;
    begin
      @(posedge I_CORE_CLK);
      I_AWADDR <= a;
      I_WDATA <= d;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
        @(negedge I_CORE_CLK);
        ta = O_AWREADY;
        tw = O_WREADY;
        tb = O_BVALID;
        rsp = O_BRESP;
        @(posedge I_CORE_CLK);
        if (ta)
          I_AWVALID <= 1'b0;
        if (tw)
          I_WVALID <= 1'b0;
      end
      I_BREADY <= 1'b0;
      @(negedge I_CORE_CLK);
      chk({O_AWREADY, O_WREADY, O_BVALID}, 3'h6);
      chk(rsp, er);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e, input [1:0] er);
    reg ta, tr;
    begin
      @(posedge I_CORE_CLK);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
        @(negedge I_CORE_CLK);
        ta = O_ARREADY;
        tr = O_RVALID;
        rd = O_RDATA;
        rsp = O_RRESP;
        @(posedge I_CORE_CLK);
        if (ta)
          I_ARVALID <= 1'b0;
      end
      I_RREADY <= 1'b0;
      @(negedge I_CORE_CLK);
      chk({O_ARREADY, O_RVALID}, 2'h2);
      chk(rd, e);
      chk(rsp, er);
    end
  endtask
  // One-cycle event pulse; wake is due two edges later
  task pulse(input [11:0] v, input w);
    begin
      @(posedge I_CORE_CLK);
      {I_GROUP_SRC_EV, I_UART_EV, I_SERIAL_MODULE_EV} <= v;
      @(posedge I_CORE_CLK);
      {I_GROUP_SRC_EV, I_UART_EV, I_SERIAL_MODULE_EV} <= 12'h000;
      @(negedge I_CORE_CLK);
      chk(O_WAKE, 1'b0);
      @(negedge I_CORE_CLK);
      chk(O_WAKE, w);
    end
  endtask
  task ret(input r);
    begin
      @(posedge I_CORE_CLK);
      I_RETURN_WITH_REENABLE <= r;
      I_PLAIN_RETURN <= !r;
      @(posedge I_CORE_CLK);
      I_RETURN_WITH_REENABLE <= 1'b0;
      I_PLAIN_RETURN <= 1'b0;
    end
  endtask
  task entry(input [1:0] id);
    begin
      while (O_VEC_REQ !== 1'b1)
        @(negedge I_CORE_CLK);
      chk(O_VEC_ID, id);
      while (O_STACK_PUSH !== 1'b1)
        @(negedge I_CORE_CLK);
      chk(O_PUSH_PC, I_PC);
      chk(O_GLOBAL_IRQ_ENABLE, 1'b0);
    end
  endtask
  // Cuts a hang short
  initial
  begin
    #1000000;
    fails = fails + 1;
    complete_run;
  end
  // Main sequence
  initial
  begin
    fails = 0;
    n_compared = 0;
    seed = 32'h00000049;
    I_CORE_CLK = 1'b0;
    I_RESETN = 1'b0;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
    {I_STACK_FULL, I_RETURN_WITH_REENABLE, I_PLAIN_RETURN} = 3'h0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_PC, lag} = 67'h0;
    {I_GROUP_SRC_EV, I_UART_EV, I_SERIAL_MODULE_EV} = 12'h000;
    I_UART_STAT_CLR = 6'h00;
    I_WSTRB = 4'hF;
    repeat (3) @(posedge I_CORE_CLK);
    I_RESETN <= 1'b1;
    repeat (3) @(posedge I_CORE_CLK);
    rdc(`SIU_CTRL_OFS, 32'h0, `SIU_RESP_OKAY);
    rdc(`SIU_FLAGS_OFS, 32'h0, `SIU_RESP_OKAY);
    rdc(8'h10, 32'h0, `SIU_RESP_SLVERR);
    wr(8'h10, 32'hFFFFFFFF, `SIU_RESP_SLVERR);
    for (i = 0; i < 4; i = i + 1)
    begin
      pulse(12'h001 << i, 1'b1);
      pulse(12'h001 << i, 1'b0);
      rdc(`SIU_FLAGS_OFS, 32'h1, `SIU_RESP_OKAY);
      wr(`SIU_FLAGS_OFS, 32'h0, `SIU_RESP_OKAY);
    end
    for (i = 0; i < 6; i = i + 1)
    begin
      pulse(12'h010 << i, i == 0);
      rdc(`SIU_STATUS_OFS, (32'h2 << i) - 1, `SIU_RESP_OKAY);
    end
    rdc(`SIU_FLAGS_OFS, 32'h2, `SIU_RESP_OKAY);
    @(posedge I_CORE_CLK);
    I_UART_STAT_CLR <= 6'h3F;
    @(posedge I_CORE_CLK);
    I_UART_STAT_CLR <= 6'h00;
    rdc(`SIU_STATUS_OFS, 32'h0, `SIU_RESP_OKAY);
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = xs(seed);
      wr(`SIU_FLAGS_OFS, 32'h0, `SIU_RESP_OKAY);
      wr(`SIU_FLAGS_OFS, seed, `SIU_RESP_OKAY);
      rdc(`SIU_FLAGS_OFS, exp_flags(seed), `SIU_RESP_OKAY);
    end
    wr(`SIU_FLAGS_OFS, 32'h0, `SIU_RESP_OKAY);
    I_STACK_FULL <= 1'b1;
    // Byte lane off: the write is answered but changes nothing
    I_WSTRB <= 4'hE;
    wr(`SIU_CTRL_OFS, 32'hF, `SIU_RESP_OKAY);
    I_WSTRB <= 4'hF;
    rdc(`SIU_CTRL_OFS, 32'h0, `SIU_RESP_OKAY);
    wr(`SIU_CTRL_OFS, 32'hF, `SIU_RESP_OKAY);
    rdc(`SIU_CTRL_OFS, 32'hF, `SIU_RESP_OKAY);
    pulse(12'h011, 1'b1);
    repeat (4) @(negedge I_CORE_CLK);
    chk(O_VEC_REQ, 1'b0);
    @(posedge I_CORE_CLK);
    seed = xs(seed);
    lag <= seed[2:0];
    I_PC <= seed[31:16];
    I_STACK_FULL <= 1'b0;
    entry(`SIU_VEC_SM);
    rdc(`SIU_FLAGS_OFS, 32'h2, `SIU_RESP_OKAY);
    ret(1'b0);
    repeat (3) @(negedge I_CORE_CLK);
    chk({O_VEC_REQ, O_GLOBAL_IRQ_ENABLE}, 32'h0);
    @(posedge I_CORE_CLK);
    seed = xs(seed);
    I_PC <= seed[15:0];
    ret(1'b1);
    @(negedge I_CORE_CLK);
    chk(O_GLOBAL_IRQ_ENABLE, 1'b1);
    entry(`SIU_VEC_UART);
    rdc(`SIU_FLAGS_OFS, 32'h0, `SIU_RESP_OKAY);
    rdc(`SIU_STATUS_OFS, 32'h1, `SIU_RESP_OKAY);
    ret(1'b1);
    @(posedge I_CORE_CLK);
    I_GROUP_SRC_EV <= 2'h1;
    I_PC <= ~I_PC;
    @(posedge I_CORE_CLK);
    I_GROUP_SRC_EV <= 2'h0;
    entry(`SIU_VEC_GRP);
    rdc(`SIU_FLAGS_OFS, 32'h8, `SIU_RESP_OKAY);
    ret(1'b1);
    complete_run;
  end
endmodule // siu_top_tb
